// [verilog/crcs_top.v]
// Chip reset and clock sequencer with an AHB-Lite register slave.
//
// Overview of operation
// - Main system clock comes from the PHY clocking; all sub-clocks derive.
// - PHY PLL turns off only on request and with every PHY powered down.
// - Oscillator may be halted while a power-saving mode is active.
// - Test option drives the oscillator output onto the interrupt pin.
// - Power-on or reset pin asserts every internal reset.
// - Strap latches follow pins during chip reset, close on release.
// - Digital reset restores soft straps from latched pins, no resampling.
// - All three resets hit core blocks and run loader; digital spares PHYs.
// - Strap-shared output pins float during chip reset, not digital reset.
// - Byte-order register reads invalid until host resets complete.
// - Ready flag in two registers sets only after whole reset completes.
// - Writes while ready is clear are ignored.
// - After chip reset release, send a 1 us active-low tuning pulse.
// - Enable output pins 2 us after the tuning pulse.
// - After pins enable, synchronise reset to system clock as master reset.
// - Master reset drives local block resets and clock generation reset.
// - PHY common, supervision and PLL keep their own internal reset.
// - Completion takes 21 ms after power-on plus 91 us per loaded byte.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "crcs_consts.vh"

module crcs_top #(
    parameter STRAP_W = 8,
    parameter NUM_PHY = 2,
    parameter [31:0] POR_CYC = `CRCS_POR_CYC,
    parameter [31:0] PIN_CYC = `CRCS_PIN_CYC,
    parameter [31:0] DIG_CYC = `CRCS_PIN_CYC,
    parameter [31:0] BYTE_CYC = `CRCS_BYTE_CYC
) (
    // Main system clock and power-on reset.
    input wire hclk,
    input wire hresetn,
    // External reset pin, active low, asynchronous.
    input wire rst_pin_n,
    // Configuration strap pins.
    input wire [STRAP_W-1:0] strap_pin,
    // AHB-Lite slave.
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // PHY power state and loader byte count, same clock.
    input wire [NUM_PHY-1:0] phy_powered_down,
    input wire [15:0] loader_bytes,
    // Clock control.
    output reg pll_enable,
    output reg osc_halt_allow,
    output reg irq_osc_select,
    // Pad tuning and strap-shared output enable.
    output reg tune_pulse_n,
    output reg strap_pin_oe,
    // Reset outputs.
    output reg master_rst_n,
    output reg clkgen_rst_n,
    output reg core_rst_n,
    output reg phy_rst_n,
    output reg loader_start,
    // Latched and soft straps, ready flag.
    output reg [STRAP_W-1:0] strap_latched,
    output reg [STRAP_W-1:0] soft_strap,
    output reg ready
);

    // Sequencer states, in the order a chip reset walks through them; S_DRST is entered only by a digital reset.
    localparam [2:0] S_TUNE = 3'd0;
    localparam [2:0] S_HOLD = 3'd1;
    localparam [2:0] S_MREL = 3'd2;
    localparam [2:0] S_LOAD = 3'd3;
    localparam [2:0] S_READY = 3'd4;
    localparam [2:0] S_DRST = 3'd5;
    // Phase lengths in system clock cycles; tune and hold follow the clock rate, DRST_CYC is a fixed 4.
    localparam [31:0] TUNE_CYC = `CRCS_TUNE_CYC;
    localparam [31:0] HOLD_CYC = `CRCS_HOLD_CYC;
    localparam [31:0] DRST_CYC = `CRCS_DRST_CYC;

    // Internal resets, synchronised straps and sequencer bookkeeping.
    wire chip_arst_n;
    wire chip_rst_n;
    reg [STRAP_W-1:0] strap_s1;
    reg [STRAP_W-1:0] strap_s2;
    reg [2:0] state;
    reg [31:0] cnt;
    reg por_cause;
    reg host_done;
    reg [4:0] pmc;
    reg dig_req;
    reg dph_write;
    reg [7:0] dph_addr;
    wire aph_valid;
    wire [31:0] load_base;
    wire [31:0] load_total;
    wire [31:0] byte_cycles;
    reg [31:0] next_rdata;
    wire wr_ok;

    // Either source drops the chip reset at once; the release is
    // synchronised so no flop leaves reset on a racing edge.
    assign chip_arst_n = hresetn & rst_pin_n;
    crcs_rst_sync u_chip_sync (
        .clk(hclk),
        .arst_n(chip_arst_n),
        .srst_n(chip_rst_n)
    );

    // Strap pins come from outside and cross two flops first.
    always @(posedge hclk) begin
        strap_s1 <= strap_pin;
        strap_s2 <= strap_s1;
    end

    // The latch is open while chip reset holds and closes on release.
    // It has no reset of its own: its reset value is the pins themselves.
    always @(posedge hclk) begin
        if (!chip_rst_n) begin
            strap_latched <= strap_s2;
        end
    end

    // Remember whether power-on caused the reset; the load time differs.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            por_cause <= 1'b1;
        end else if (state == S_READY) begin
            por_cause <= 1'b0;
        end
    end

    // Loader time grows with the bytes it fetches.
    assign byte_cycles = BYTE_CYC * {16'h0000, loader_bytes};
    assign load_base = por_cause ? POR_CYC : PIN_CYC;
    assign load_total = load_base + byte_cycles;

    // Sequencer: tune, hold, release master reset, load, ready.
    always @(posedge hclk or negedge chip_rst_n) begin
        if (!chip_rst_n) begin
            state <= S_TUNE;
            cnt <= 32'h0000_0000;
            tune_pulse_n <= 1'b1;
            strap_pin_oe <= 1'b0;
            master_rst_n <= 1'b0;
            clkgen_rst_n <= 1'b0;
            core_rst_n <= 1'b0;
            phy_rst_n <= 1'b0;
            loader_start <= 1'b0;
            ready <= 1'b0;
            host_done <= 1'b0;
        end else begin
            loader_start <= 1'b0;
            case (state)
                S_TUNE: begin
                    // The pulse drops on the first edge out of reset and
                    // rises on the edge that sees the full count, so it is
                    // low for exactly TUNE_CYC cycles.
                    tune_pulse_n <= 1'b0;
                    if (cnt == TUNE_CYC) begin
                        tune_pulse_n <= 1'b1;
                        cnt <= 32'h0000_0000;
                        state <= S_HOLD;
                    end else begin
                        cnt <= cnt + 32'h0000_0001;
                    end
                end
                S_HOLD: begin
                    if (cnt == HOLD_CYC - 32'h0000_0001) begin
                        strap_pin_oe <= 1'b1;
                        cnt <= 32'h0000_0000;
                        state <= S_MREL;
                    end else begin
                        cnt <= cnt + 32'h0000_0001;
                    end
                end
                S_MREL: begin
                    // Pins are out; the release is now on the system clock.
                    master_rst_n <= 1'b1;
                    clkgen_rst_n <= 1'b1;
                    core_rst_n <= 1'b1;
                    phy_rst_n <= 1'b1;
                    host_done <= 1'b1;
                    loader_start <= 1'b1;
                    cnt <= load_total;
                    state <= S_LOAD;
                end
                S_LOAD: begin
                    // Stopping at one raises ready exactly cnt edges after
                    // the start; the less-than keeps a zero count from wrapping.
                    if (cnt <= 32'h0000_0001) begin
                        ready <= 1'b1;
                        state <= S_READY;
                    end else begin
                        cnt <= cnt - 32'h0000_0001;
                    end
                end
                S_READY: begin
                    if (dig_req) begin
                        // PHYs stay up and pins keep driving.
                        ready <= 1'b0;
                        host_done <= 1'b0;
                        core_rst_n <= 1'b0;
                        cnt <= 32'h0000_0000;
                        state <= S_DRST;
                    end
                end
                S_DRST: begin
                    // Only the core reset is pulsed; PHYs and pin drivers keep
                    // running, so links stay up across a digital reset.
                    if (cnt == DRST_CYC - 32'h0000_0001) begin
                        core_rst_n <= 1'b1;
                        host_done <= 1'b1;
                        loader_start <= 1'b1;
                        cnt <= DIG_CYC + byte_cycles;
                        state <= S_LOAD;
                    end else begin
                        cnt <= cnt + 32'h0000_0001;
                    end
                end
                default: begin
                    state <= S_TUNE;
                    cnt <= 32'h0000_0000;
                end
            endcase
        end
    end

    // AHB-Lite address phase; the slave never stretches a transfer.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign aph_valid = hsel & hready & htrans[1];
    assign wr_ok = dph_write & ready;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_write <= 1'b0;
            dph_addr <= 8'h00;
        end else if (hready) begin
            dph_write <= aph_valid & hwrite;
            dph_addr <= haddr;
        end
    end

    // Soft straps reload from the latched pins on any reset, and software
    // may change them only once the device is ready.
    always @(posedge hclk or negedge chip_rst_n) begin
        if (!chip_rst_n) begin
            soft_strap <= {STRAP_W{1'b0}};
        end else if (state == S_TUNE || state == S_DRST) begin
            soft_strap <= strap_latched;
        end else if (wr_ok && dph_addr == `CRCS_OFS_HW_CONFIG) begin
            soft_strap <= hwdata[STRAP_W-1:0];
        end
    end

    // Clock control bits; a digital reset leaves them alone.
    always @(posedge hclk or negedge chip_rst_n) begin
        if (!chip_rst_n) begin
            pmc <= `CRCS_PMC_RESET;
        end else if (wr_ok && dph_addr == `CRCS_OFS_PWR_MGMT) begin
            pmc <= hwdata[4:0];
        end
    end

    // Digital reset request; the sequencer consumes it the next cycle.
    always @(posedge hclk or negedge chip_rst_n) begin
        if (!chip_rst_n) begin
            dig_req <= 1'b0;
        end else if (state == S_DRST) begin
            dig_req <= 1'b0;
        end else if (wr_ok && dph_addr == `CRCS_OFS_RESET_CONTROL_REG) begin
            dig_req <= hwdata[`CRCS_RSC_DIGITAL];
        end
    end

    // The PLL and oscillator controls sit outside the PHY's own reset
    // domain, so only the chip reset touches them here.
    always @(posedge hclk or negedge chip_rst_n) begin
        if (!chip_rst_n) begin
            pll_enable <= 1'b1;
            osc_halt_allow <= 1'b0;
            irq_osc_select <= 1'b0;
        end else begin
            pll_enable <= ~(pmc[`CRCS_PMC_PLL_DIS] & (&phy_powered_down));
            osc_halt_allow <= pmc[`CRCS_PMC_OSC_HALT] &
                pmc[`CRCS_PMC_PWR_SAVE];
            irq_osc_select <= pmc[`CRCS_PMC_CLK_TEST];
        end
    end

    // Read mux for the next data phase.
    // The byte-order pattern stays invalid until the host side is out
    // of reset, so software may poll it from the first cycle.
    always @* begin
        next_rdata = 32'h0000_0000;
        case (haddr)
            `CRCS_OFS_BYTE_TEST: begin
                next_rdata = host_done ? `CRCS_BYTE_TEST_VALUE :
                    `CRCS_BYTE_TEST_INVALID;
            end
            `CRCS_OFS_HW_CONFIG: begin
                next_rdata[`CRCS_HWC_READY] = ready;
                next_rdata[STRAP_W-1:0] = soft_strap;
                next_rdata[`CRCS_HWC_LATCH_LSB+STRAP_W-1:
                    `CRCS_HWC_LATCH_LSB] = strap_latched;
            end
            `CRCS_OFS_PWR_MGMT: begin
                next_rdata[4:0] = pmc;
                next_rdata[`CRCS_PMC_READY] = ready;
                next_rdata[`CRCS_PMC_PLL_OFF] = ~pll_enable;
            end
            `CRCS_OFS_RESET_CONTROL_REG: begin
                next_rdata[`CRCS_RSC_DIGITAL] = dig_req | (state == S_DRST);
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Read data is registered at the address phase and stands in the data
    // phase; hresetn, not chip reset, clears it so the bus stays sane.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (aph_valid && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

endmodule // crcs_top

`default_nettype wire

// [verilog/crcs_consts.vh]
// Constants for the chip reset and clock sequencer.
`ifndef CRCS_CONSTS_VH
`define CRCS_CONSTS_VH

// Clock rate of the main system clock, in MHz.
`define CRCS_CLK_MHZ 10

// Times as printed, and the derived cycle counts.
`define CRCS_TUNE_US 1
`define CRCS_HOLD_US 2
`define CRCS_POR_MS 21
`define CRCS_PIN_US 760
`define CRCS_BYTE_US 91
`define CRCS_TUNE_CYC (`CRCS_TUNE_US * `CRCS_CLK_MHZ)
`define CRCS_HOLD_CYC (`CRCS_HOLD_US * `CRCS_CLK_MHZ)
`define CRCS_POR_CYC (`CRCS_POR_MS * 1000 * `CRCS_CLK_MHZ)
`define CRCS_PIN_CYC (`CRCS_PIN_US * `CRCS_CLK_MHZ)
`define CRCS_BYTE_CYC (`CRCS_BYTE_US * `CRCS_CLK_MHZ)
`define CRCS_DRST_CYC 4

// Register byte offsets.
`define CRCS_OFS_BYTE_TEST 8'h00
`define CRCS_OFS_HW_CONFIG 8'h04
`define CRCS_OFS_PWR_MGMT 8'h08
`define CRCS_OFS_RESET_CONTROL_REG 8'h0C

// Field positions.
`define CRCS_HWC_READY 27
`define CRCS_HWC_LATCH_LSB 8
`define CRCS_PMC_READY 0
`define CRCS_PMC_PLL_DIS 1
`define CRCS_PMC_OSC_HALT 2
`define CRCS_PMC_PWR_SAVE 3
`define CRCS_PMC_CLK_TEST 4
`define CRCS_PMC_PLL_OFF 8
`define CRCS_RSC_DIGITAL 0

// Reset values and fixed patterns.
`define CRCS_BYTE_TEST_VALUE 32'h8765_4321
`define CRCS_BYTE_TEST_INVALID 32'h0000_0000
`define CRCS_PMC_RESET 5'h00

`endif

// [verilog/crcs_rst_sync.v]
// Reset synchroniser: asserts at once, releases after two clock edges.
`timescale 1ns/1ps
`default_nettype none

module crcs_rst_sync (
    // Clock and raw asynchronous reset.
    input wire clk,
    input wire arst_n,
    // Synchronised reset.
    output wire srst_n
);

    reg stage1;
    reg stage2;

    // Only the second flop is seen outside, so a metastable first stage
    // has a whole cycle to settle before anything reads it.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= 1'b1;
            stage2 <= stage1;
        end
    end

    assign srst_n = stage2;

endmodule // crcs_rst_sync

`default_nettype wire

// [sim/crcs_sva.sv]
// Assertion checker for the chip reset and clock sequencer ports.
`timescale 1ns/1ps
`default_nettype none
module crcs_sva #(
    parameter STRAP_W = 8,
    parameter NUM_PHY = 2
) (
    // Clock and reset sources.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic rst_pin_n,
    // PHY power state.
    input wire logic [NUM_PHY-1:0] phy_powered_down,
    // Sequencer outputs.
    input wire logic pll_enable,
    input wire logic tune_pulse_n,
    input wire logic strap_pin_oe,
    input wire logic master_rst_n,
    input wire logic clkgen_rst_n,
    input wire logic core_rst_n,
    input wire logic phy_rst_n,
    input wire logic loader_start,
    input wire logic [STRAP_W-1:0] strap_latched,
    input wire logic ready
);
    // Sequence checks pause while either chip reset source is low; AST_CHIP_RST pauses on hresetn only.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn || !rst_pin_n);

    AST_PLL_OFF: assert property (!pll_enable |->
        $past(&phy_powered_down))
        else $error("PLL off while a PHY is powered");
    AST_CHIP_RST: assert property (disable iff (!hresetn)
        !rst_pin_n |-> !master_rst_n && !core_rst_n && !phy_rst_n &&
        !clkgen_rst_n && !ready && !strap_pin_oe && tune_pulse_n)
        else $error("pin reset did not hold every reset");
    AST_TUNE: assert property ($fell(tune_pulse_n) |->
        (!tune_pulse_n)[*8] ##1 (!tune_pulse_n)[*2] ##1 tune_pulse_n)
        else $error("tuning pulse length wrong");
    AST_HOLD: assert property ($rose(tune_pulse_n) |->
        (!strap_pin_oe)[*8] ##1 (!strap_pin_oe)[*8] ##1
        (!strap_pin_oe)[*4] ##1 strap_pin_oe)
        else $error("output enable delay wrong");
    AST_MRST: assert property ($rose(master_rst_n) |->
        $past(strap_pin_oe) && clkgen_rst_n && phy_rst_n)
        else $error("master reset released out of order");
    AST_LOAD: assert property ($rose(core_rst_n) |-> loader_start
        ##1 !loader_start)
        else $error("loader not started on core release");
    AST_DIG: assert property ($fell(core_rst_n) |->
        (!core_rst_n && phy_rst_n && strap_pin_oe)[*4] ##1 core_rst_n)
        else $error("digital reset shape wrong");
    AST_READY: assert property ($rose(ready) |-> master_rst_n &&
        core_rst_n && !loader_start)
        else $error("ready set before reset done");
    AST_LATCH: assert property (strap_pin_oe &&
        $past(strap_pin_oe) |-> $stable(strap_latched))
        else $error("latched straps moved");
endmodule // crcs_sva
`default_nettype wire

// [sim/crcs_board.sv]
// Board model: reset pin source and strap pins shared with outputs.
`timescale 1ns/1ps
`default_nettype none
module crcs_board (
    // Clock and requests from the bench.
    input wire logic clk,
    input wire logic pin_req,
    input wire logic [7:0] strap_val,
    // Device drive on the strap-shared pins.
    input wire logic strap_pin_oe,
    // Pins seen by the device.
    output logic rst_pin_n,
    output logic [7:0] strap_pin
);
    logic [2:0] hold_cnt = 3'h0;
    logic [7:0] churn = 8'h00;
    // Hold the pin low four edges; churn shows pins the board let go.
    always @(posedge clk) begin
        if (pin_req) begin
            hold_cnt <= 3'h4;
        end else if (hold_cnt != 3'h0) begin
            hold_cnt <= hold_cnt - 3'h1;
        end
        churn <= churn + 8'h35;
    end
    // Once the device drives, the strap value is no longer on the pins.
    assign rst_pin_n = (hold_cnt == 3'h0);
    assign strap_pin = strap_pin_oe ? churn : strap_val;
endmodule // crcs_board
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking testbench for the chip reset and clock sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int P_POR = 50;
    localparam int P_PIN = 30;
    localparam int P_BYTE = 2;
    localparam int LIMIT = 20000;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pin_req, rst_pin_n;
    logic [7:0] haddr, strap_val, strap_pin, strap_latched, soft_strap;
    logic [1:0] htrans, phy_powered_down;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd, v, ld_cnt, cyc;
    logic [15:0] loader_bytes;
    logic pll_enable, osc_halt_allow, irq_osc_select, tune_pulse_n;
    logic strap_pin_oe, master_rst_n, clkgen_rst_n, core_rst_n, phy_rst_n;
    logic loader_start, ready;
    int fail_count = 0;
    int tests_run = 0;

    crcs_top #(.POR_CYC(P_POR), .PIN_CYC(P_PIN), .DIG_CYC(P_PIN),
        .BYTE_CYC(P_BYTE)) i_dut (.hclk(hclk), .hresetn(hresetn),
        .rst_pin_n(rst_pin_n), .strap_pin(strap_pin), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .phy_powered_down(phy_powered_down),
        .loader_bytes(loader_bytes), .pll_enable(pll_enable),
        .osc_halt_allow(osc_halt_allow), .irq_osc_select(irq_osc_select),
        .tune_pulse_n(tune_pulse_n), .strap_pin_oe(strap_pin_oe),
        .master_rst_n(master_rst_n), .clkgen_rst_n(clkgen_rst_n),
        .core_rst_n(core_rst_n), .phy_rst_n(phy_rst_n),
        .loader_start(loader_start), .strap_latched(strap_latched),
        .soft_strap(soft_strap), .ready(ready));
    crcs_board i_board (.clk(hclk), .pin_req(pin_req), .strap_val(strap_val),
        .strap_pin_oe(strap_pin_oe), .rst_pin_n(rst_pin_n),
        .strap_pin(strap_pin));

    // Clock of 100 ns period.
    always #50 hclk = ~hclk;

    // Load length counter and hang guard.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (loader_start === 1'b1) begin
            ld_cnt <= 0;
        end else if (ready !== 1'b1) begin
            ld_cnt <= ld_cnt + 1;
        end
        if (cyc == LIMIT) begin
            fail_count = fail_count + 1;
            $display("ERROR timeout expected done seen hang");
            give_verdict();
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic int exp_load(input int base);
        return base + P_BYTE * int'(loader_bytes);
    endfunction

    // One single AHB-Lite word transfer; entered just after a rising edge.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rdat);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdat = hrdata;
        check("hresp", hresp, 0);
    endtask

    // Waits for ready, then checks the state every reset must leave.
    task automatic after_ready(input string name, input int base);
        int e;
        while (ready !== 1'b1) @(posedge hclk);
        e = exp_load(base);
        check("load_time", ld_cnt, e - 1);
        bus(1'b0, 8'h00, 0, rd);
        check("byte_test", rd, 32'h8765_4321);
        bus(1'b0, 8'h04, 0, rd);
        check("hw_ready", rd[27], 1);
        check("hw_latched", rd[15:8], strap_val);
        check("hw_soft", rd[7:0], strap_val);
        bus(1'b0, 8'h08, 0, rd);
        check("pm_ready", rd[0], 1);
        bus(1'b0, 8'h0c, 0, rd);
        check("rst_idle", rd[0], 0);
        bus(1'b0, 8'h10, 0, rd);
        check("unmapped", rd, 0);
        check("latched_port", strap_latched, strap_val);
        $display("test %s done", name);
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        hclk = 0;
        hresetn = 0;
        {hsel, hwrite, pin_req, phy_powered_down, htrans} = 0;
        {haddr, hwdata, cyc, ld_cnt} = 0;
        hsize = 3'h2;
        v = $urandom(92670);
        strap_val = 8'($urandom);
        loader_bytes = 16'($urandom_range(7, 0));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Only the byte-order register is read before ready.
        bus(1'b0, 8'h00, 0, rd);
        check("byte_early", rd, 0);
        // Write in the load phase, where only the ready gate can stop it.
        repeat (40) @(posedge hclk);
        bus(1'b1, 8'h04, {24'h0, ~strap_val}, rd);
        after_ready("power_on", P_POR);
        // Clock control bits against PHY power state, corner first.
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            if (i == 0) v[6:1] = 6'h3f;
            phy_powered_down <= v[6:5];
            bus(1'b1, 8'h08, {27'h0, v[4:1], 1'b0}, rd);
            repeat (3) @(posedge hclk);
            check("pll_enable", pll_enable, !(v[1] && &v[6:5]));
            check("osc_halt", osc_halt_allow, v[2] & v[3]);
            check("irq_osc", irq_osc_select, v[4]);
            bus(1'b0, 8'h08, 0, rd);
            check("pm_bits", rd[4:0], {v[4:1], 1'b1});
            check("pll_off", rd[8], v[1] && &v[6:5]);
        end
        $display("test clock_control done");
        v = $urandom;
        bus(1'b1, 8'h04, v, rd);
        bus(1'b0, 8'h04, 0, rd);
        check("soft_rw", rd[7:0], v[7:0]);
        check("soft_port", soft_strap, v[7:0]);
        bus(1'b1, 8'h0c, 1, rd);
        bus(1'b0, 8'h0c, 0, rd);
        check("rst_pending", rd[0], 1);
        while (ready !== 1'b0) @(posedge hclk);
        check("dig_oe", strap_pin_oe, 1);
        check("dig_phy", phy_rst_n, 1);
        // Let the short core reset pass so the write meets the load phase.
        repeat (8) @(posedge hclk);
        bus(1'b1, 8'h04, ~v, rd);
        after_ready("digital", P_PIN);
        strap_val <= 8'($urandom);
        pin_req <= 1'b1;
        @(posedge hclk);
        pin_req <= 1'b0;
        while (rst_pin_n !== 1'b0) @(posedge hclk);
        while (rst_pin_n !== 1'b1) @(posedge hclk);
        bus(1'b0, 8'h00, 0, rd);
        check("byte_pin_early", rd, 0);
        after_ready("pin_reset", P_PIN);
        give_verdict();
    end
endmodule // tb_top

bind crcs_top crcs_sva #(.STRAP_W(STRAP_W), .NUM_PHY(NUM_PHY)) i_sva (
    .hclk(hclk), .hresetn(hresetn), .rst_pin_n(rst_pin_n),
    .phy_powered_down(phy_powered_down), .pll_enable(pll_enable),
    .tune_pulse_n(tune_pulse_n), .strap_pin_oe(strap_pin_oe),
    .master_rst_n(master_rst_n), .clkgen_rst_n(clkgen_rst_n),
    .core_rst_n(core_rst_n), .phy_rst_n(phy_rst_n),
    .loader_start(loader_start), .strap_latched(strap_latched),
    .ready(ready));
`default_nettype wire
